// ---- rtl/cfsp_core.sv ----
// condition flags register, stack pointer and context push/pop sequencer
//
// Function
// - half carry bit 4 follows carry out of bit 3 on add and add-with-carry
// - mask bit 3 set on interrupt entry or by software; blocks all but trap
// - mask cleared only by mask reset, flags load or return from interrupt
// - requests arriving while masked stay latched until unmasked
// - clearing mask in a handler takes pending requests at once, no priority
// - negative bit 2 copies result msb after each data operation
// - zero bit 1 set when result is zero, else cleared
// - carry bit 0 shows over/underflow; set/reset instructions, shifts, bit tests
// - flags pushed and popped as one byte; each flag testable by branches
// - stack pointer names next free byte; post-decrement push, pre-increment pop
// - stack holds 128 bytes; upper nine pointer bits fixed
// - reset or pointer reset instruction loads 017F
// - pointer low byte readable and writable by load
// - pointer wraps silently past bottom or top of stack
// - interrupt entry writes program counter low first at pointer
// - call uses two stack bytes, interrupt five
// - interrupt saves program counter, x, accumulator and flags; return restores
// - y index register is never saved or restored automatically
`timescale 1ns/1ps
`include "cfsp_defs.svh"
module cfsp_core #(
  parameter int STACK_AW = 7
) (
  input wire logic clk,
  input wire logic rst,
  input wire cfsp_pkg::cfsp_op_t flag_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [7:0] alu_result,
  input wire logic alu_carry,
  input wire logic flags_wr,
  input wire logic [7:0] flags_wdata,
  input wire cfsp_pkg::cfsp_branch_t branch_sel,
  input wire logic sp_reset_instruction,
  input wire logic sp_low_wr,
  input wire logic [7:0] sp_low_wdata,
  input wire logic push_req,
  input wire logic [7:0] push_data,
  input wire logic pop_req,
  input wire logic irq_req,
  input wire logic trap_req,
  input wire logic call_req,
  input wire logic ret_req,
  input wire logic return_from_interrupt_instruction_req,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] x_in,
  input wire logic [7:0] acc_in,
  output logic [7:0] flags_q,
  output logic [15:0] sp_q,
  output logic branch_taken_q,
  output logic irq_pending_q,
  output logic irq_take_q,
  output logic busy_q,
  output logic [7:0] pop_data_q,
  output logic pop_valid_q,
  output logic [15:0] pc_out_q,
  output logic [7:0] x_out_q,
  output logic [7:0] acc_out_q,
  output logic restore_done_q
);
  import cfsp_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] sp_step(input logic [15:0] sp, input logic up);
    logic [6:0] lo;
    lo = up ? sp[6:0] + 7'h01 : sp[6:0] - 7'h01;
    sp_step = {`CFSP_SP_HIGH, lo};
  endfunction

  function automatic logic [7:0] fix_flags(input logic [7:0] f);
    fix_flags = f | `CFSP_FLAGS_FIXED;
  endfunction

  // ----------------------------------------
  // flag update
  // ----------------------------------------
  cfsp_state_t state_q;
  logic [2:0] step_q;
  logic [2:0] len_q;
  logic [7:0] ctx_flags_q;
  logic restore_q;
  logic ram_we;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic rd_pend_q;
  logic [2:0] rd_step_q;
  logic seq_pop_done;
  logic [7:0] half_sum;
  logic enter_ctx;

  assign half_sum = {4'h0, alu_a[3:0]} + {4'h0, alu_b[3:0]}
    + {7'h00, (flag_op == CFSP_OP_ADC) ? flags_q[`CFSP_BIT_C] : 1'b0};
  assign enter_ctx = (state_q == CFSP_ST_IDLE) && (trap_req || irq_take_q);
  // flags byte is the first one back, only a five-byte frame reaches step 4
  logic flags_restore;
  assign flags_restore = restore_q && rd_pend_q && rd_step_q == 3'h4;

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= `CFSP_FLAGS_RST;
    end else if (flags_restore) begin
      flags_q <= fix_flags(ram_rdata);
    end else if (enter_ctx) begin
      flags_q[`CFSP_BIT_I] <= 1'b1;
    end else if (flags_wr) begin
      flags_q <= fix_flags(flags_wdata);
    end else begin
      unique case (flag_op)
        CFSP_OP_ADD, CFSP_OP_ADC: begin
          flags_q[`CFSP_BIT_H] <= half_sum[4];
          flags_q[`CFSP_BIT_N] <= alu_result[7];
          flags_q[`CFSP_BIT_Z] <= alu_result == 8'h00;
          flags_q[`CFSP_BIT_C] <= alu_carry;
        end
        CFSP_OP_SUB, CFSP_OP_SHIFT: begin
          flags_q[`CFSP_BIT_N] <= alu_result[7];
          flags_q[`CFSP_BIT_Z] <= alu_result == 8'h00;
          flags_q[`CFSP_BIT_C] <= alu_carry;
        end
        CFSP_OP_LOGIC: begin
          flags_q[`CFSP_BIT_N] <= alu_result[7];
          flags_q[`CFSP_BIT_Z] <= alu_result == 8'h00;
        end
        CFSP_OP_BTJ: flags_q[`CFSP_BIT_C] <= alu_carry;
        CFSP_OP_SCF: flags_q[`CFSP_BIT_C] <= 1'b1;
        CFSP_OP_RCF: flags_q[`CFSP_BIT_C] <= 1'b0;
        CFSP_OP_SIM: flags_q[`CFSP_BIT_I] <= 1'b1;
        CFSP_OP_RIM: flags_q[`CFSP_BIT_I] <= 1'b0;
        CFSP_OP_NONE: flags_q <= flags_q;
        default: flags_q <= flags_q;
      endcase
    end
  end

  // ----------------------------------------
  // branch tests
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      branch_taken_q <= 1'b0;
    end else begin
      unique case (branch_sel)
        CFSP_BR_HALF: branch_taken_q <= flags_q[`CFSP_BIT_H];
        CFSP_BR_NO_HALF: branch_taken_q <= !flags_q[`CFSP_BIT_H];
        CFSP_BR_MASKED: branch_taken_q <= flags_q[`CFSP_BIT_I];
        CFSP_BR_UNMASKED: branch_taken_q <= !flags_q[`CFSP_BIT_I];
        CFSP_BR_MINUS: branch_taken_q <= flags_q[`CFSP_BIT_N];
        CFSP_BR_PLUS: branch_taken_q <= !flags_q[`CFSP_BIT_N];
        CFSP_BR_EQUAL: branch_taken_q <= flags_q[`CFSP_BIT_Z];
        CFSP_BR_NOT_EQUAL: branch_taken_q <= !flags_q[`CFSP_BIT_Z];
        CFSP_BR_CARRY: branch_taken_q <= flags_q[`CFSP_BIT_C];
        CFSP_BR_NO_CARRY: branch_taken_q <= !flags_q[`CFSP_BIT_C];
        default: branch_taken_q <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // interrupt latch
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_pending_q <= 1'b0;
    end else if (irq_req) begin
      irq_pending_q <= 1'b1;
    end else if (enter_ctx && irq_take_q) begin
      irq_pending_q <= 1'b0;
    end
  end

  // take fires as soon as mask is clear, regardless of handler depth
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_take_q <= 1'b0;
    end else begin
      irq_take_q <= irq_pending_q && !irq_take_q && !flags_q[`CFSP_BIT_I]
        && state_q == CFSP_ST_IDLE && !trap_req;
    end
  end

  // ----------------------------------------
  // push / pop sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= CFSP_ST_IDLE;
      step_q <= 3'h0;
      len_q <= 3'h0;
      ctx_flags_q <= 8'h00;
      restore_q <= 1'b0;
    end else begin
      unique case (state_q)
        CFSP_ST_IDLE: begin
          step_q <= 3'h0;
          if (enter_ctx) begin
            state_q <= CFSP_ST_PUSH;
            len_q <= `CFSP_IRQ_BYTES;
            ctx_flags_q <= flags_q;
          end else if (call_req) begin
            state_q <= CFSP_ST_PUSH;
            len_q <= `CFSP_CALL_BYTES;
          end else if (return_from_interrupt_instruction_req) begin
            state_q <= CFSP_ST_POP;
            len_q <= `CFSP_IRQ_BYTES;
            restore_q <= 1'b1;
          end else if (ret_req) begin
            state_q <= CFSP_ST_POP;
            len_q <= `CFSP_CALL_BYTES;
            restore_q <= 1'b1;
          end
        end
        CFSP_ST_PUSH: begin
          step_q <= step_q + 3'h1;
          if (step_q == len_q - 3'h1) begin
            state_q <= CFSP_ST_IDLE;
          end
        end
        CFSP_ST_POP: begin
          step_q <= step_q + 3'h1;
          if (step_q == len_q - 3'h1) begin
            state_q <= CFSP_ST_IDLE;
          end
        end
        default: state_q <= CFSP_ST_IDLE;
      endcase
      if (seq_pop_done) begin
        restore_q <= 1'b0;
      end
    end
  end

  // context bytes: pcl, pch, x, a, flags; y is never included
  always_comb begin
    ram_we = 1'b0;
    ram_wdata = 8'h00;
    if (state_q == CFSP_ST_PUSH) begin
      ram_we = 1'b1;
      unique case (step_q)
        3'h0: ram_wdata = pc_in[7:0];
        3'h1: ram_wdata = pc_in[15:8];
        3'h2: ram_wdata = x_in;
        3'h3: ram_wdata = acc_in;
        3'h4: ram_wdata = ctx_flags_q;
        default: ram_wdata = 8'h00;
      endcase
    end else if (state_q == CFSP_ST_IDLE && push_req && !enter_ctx && !call_req
      && !return_from_interrupt_instruction_req && !ret_req) begin
      ram_we = 1'b1;
      ram_wdata = push_data;
    end
  end

  // ----------------------------------------
  // stack pointer
  // ----------------------------------------
  logic user_pop;
  assign user_pop = state_q == CFSP_ST_IDLE && pop_req && !enter_ctx && !call_req
    && !return_from_interrupt_instruction_req && !ret_req && !push_req;

  always_ff @(posedge clk) begin
    if (rst || sp_reset_instruction) begin
      sp_q <= `CFSP_SP_RST;
    end else if (ram_we) begin
      sp_q <= sp_step(sp_q, 1'b0);
    end else if (state_q == CFSP_ST_POP || user_pop) begin
      sp_q <= sp_step(sp_q, 1'b1);
    end else if (sp_low_wr) begin
      sp_q <= {`CFSP_SP_HIGH, sp_low_wdata[6:0]};
    end
  end

  // pre-increment: read address is pointer plus one
  logic [15:0] sp_next_up;
  assign sp_next_up = sp_step(sp_q, 1'b1);

  cfsp_stack_ram #(
    .AW(STACK_AW)
  ) u_ram (
    .clk(clk),
    .we(ram_we),
    .waddr(sp_q[STACK_AW-1:0]),
    .wdata(ram_wdata),
    .raddr(sp_next_up[STACK_AW-1:0]),
    .rdata(ram_rdata)
  );

  // ----------------------------------------
  // pop data return
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      rd_step_q <= 3'h0;
    end else begin
      rd_pend_q <= state_q == CFSP_ST_POP || user_pop;
      rd_step_q <= (state_q == CFSP_ST_POP) ? len_q - 3'h1 - step_q : 3'h7;
    end
  end

  assign seq_pop_done = restore_q && rd_pend_q && rd_step_q == 3'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      pop_data_q <= 8'h00;
      pop_valid_q <= 1'b0;
      pc_out_q <= 16'h0000;
      x_out_q <= 8'h00;
      acc_out_q <= 8'h00;
      restore_done_q <= 1'b0;
    end else begin
      pop_valid_q <= rd_pend_q && !restore_q;
      restore_done_q <= seq_pop_done;
      if (rd_pend_q) begin
        pop_data_q <= ram_rdata;
      end
      if (restore_q && rd_pend_q) begin
        unique case (rd_step_q)
          3'h0: pc_out_q[7:0] <= ram_rdata;
          3'h1: pc_out_q[15:8] <= ram_rdata;
          3'h2: x_out_q <= ram_rdata;
          3'h3: acc_out_q <= ram_rdata;
          default: pc_out_q <= pc_out_q;
        endcase
      end
    end
  end

  // return_from_interrupt_instruction pops flags first at step 4; ret pops pch then pcl
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= state_q != CFSP_ST_IDLE || enter_ctx || call_req || return_from_interrupt_instruction_req || ret_req;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_sp_high_fixed: assert property (@(posedge clk) disable iff (rst)
    sp_q[15:7] == `CFSP_SP_HIGH) else $error("stack pointer high bits moved");
  a_sp_reset_value: assert property (@(posedge clk)
    sp_reset_instruction |=> sp_q == `CFSP_SP_RST) else $error("pointer reset wrong");
  a_mask_on_entry: assert property (@(posedge clk) disable iff (rst)
    enter_ctx |=> flags_q[`CFSP_BIT_I]) else $error("mask not set on entry");
  a_mask_clear_cause: assert property (@(posedge clk) disable iff (rst)
    $fell(flags_q[`CFSP_BIT_I]) |-> $past(flag_op) == CFSP_OP_RIM || $past(flags_wr)
    || $past(flags_restore)) else $error("mask cleared without cause");
  a_irq_held: assert property (@(posedge clk) disable iff (rst)
    irq_pending_q && flags_q[`CFSP_BIT_I] |=> irq_pending_q) else $error("irq lost");
  a_irq_length: assert property (@(posedge clk) disable iff (rst)
    enter_ctx |=> ##5 sp_q[6:0] == $past(sp_q[6:0], 6) - 7'h05)
    else $error("interrupt frame size wrong");
  a_push_dec: assert property (@(posedge clk) disable iff (rst)
    ram_we && !sp_reset_instruction |=> sp_q[6:0] == $past(sp_q[6:0]) - 7'h01)
    else $error("push did not decrement");
  a_zero_flag: assert property (@(posedge clk) disable iff (rst)
    flag_op == CFSP_OP_LOGIC && !flags_wr && !enter_ctx && !restore_q
    |=> flags_q[`CFSP_BIT_Z] == ($past(alu_result) == 8'h00)) else $error("zero flag");
  a_neg_flag: assert property (@(posedge clk) disable iff (rst)
    flag_op == CFSP_OP_SUB && !flags_wr && !enter_ctx && !restore_q
    |=> flags_q[`CFSP_BIT_N] == $past(alu_result[7])) else $error("negative flag");
endmodule

// ---- rtl/cfsp_defs.svh ----
// constants for the cpu flag register and stack pointer block
`ifndef CFSP_DEFS_SVH
`define CFSP_DEFS_SVH
`define CFSP_BIT_H 4
`define CFSP_BIT_I 3
`define CFSP_BIT_N 2
`define CFSP_BIT_Z 1
`define CFSP_BIT_C 0
`define CFSP_FLAGS_RST 8'hE8
`define CFSP_FLAGS_FIXED 8'hE0
`define CFSP_SP_RST 16'h017F
`define CFSP_SP_HIGH 9'h002
`define CFSP_CALL_BYTES 3'h2
`define CFSP_IRQ_BYTES 3'h5
`endif

// ---- rtl/cfsp_pkg.sv ----
// types for the cpu flag register and stack pointer block
package cfsp_pkg;
  typedef enum logic [3:0] {
    CFSP_OP_NONE,
    CFSP_OP_ADD,
    CFSP_OP_ADC,
    CFSP_OP_LOGIC,
    CFSP_OP_SUB,
    CFSP_OP_SHIFT,
    CFSP_OP_BTJ,
    CFSP_OP_SCF,
    CFSP_OP_RCF,
    CFSP_OP_SIM,
    CFSP_OP_RIM
  } cfsp_op_t;
  typedef enum logic [3:0] {
    CFSP_BR_HALF,
    CFSP_BR_NO_HALF,
    CFSP_BR_MASKED,
    CFSP_BR_UNMASKED,
    CFSP_BR_MINUS,
    CFSP_BR_PLUS,
    CFSP_BR_EQUAL,
    CFSP_BR_NOT_EQUAL,
    CFSP_BR_CARRY,
    CFSP_BR_NO_CARRY
  } cfsp_branch_t;
  typedef enum logic [1:0] {
    CFSP_ST_IDLE,
    CFSP_ST_PUSH,
    CFSP_ST_POP
  } cfsp_state_t;
endpackage

// ---- rtl/cfsp_stack_ram.sv ----
// 128-byte stack memory with registered read data
`timescale 1ns/1ps
module cfsp_stack_ram #(
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule

// ---- test/cfsp_tb.sv ----
// self-checking bench for the flag register and stack pointer block
`timescale 1ns/1ps
module testbench;
  import cfsp_pkg::*;
  logic clk, rst;
  cfsp_op_t flag_op;
  cfsp_branch_t branch_sel;
  logic [7:0] alu_a, alu_b, alu_result, flags_wdata, sp_low_wdata, push_data, x_in, acc_in;
  logic alu_carry, flags_wr, sp_reset_instruction, sp_low_wr, push_req, pop_req;
  logic irq_req, trap_req, call_req, ret_req, return_from_interrupt_instruction_req;
  logic [15:0] pc_in;
  logic [7:0] flags_q, pop_data_q, x_out_q, acc_out_q, fv, d;
  logic [15:0] sp_q, pc_out_q;
  logic branch_taken_q, irq_pending_q, irq_take_q, busy_q, pop_valid_q, restore_done_q;
  logic [7:0] ctx [5] = '{8'hE8, 8'h22, 8'h11, 8'h24, 8'h68};
  int mismatches, cmp_count;
  int done_cnt, take_cnt;

  `define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

  cfsp_core dut (
    .clk(clk), .rst(rst), .flag_op(flag_op), .alu_a(alu_a), .alu_b(alu_b),
    .alu_result(alu_result), .alu_carry(alu_carry), .flags_wr(flags_wr),
    .flags_wdata(flags_wdata), .branch_sel(branch_sel),
    .sp_reset_instruction(sp_reset_instruction), .sp_low_wr(sp_low_wr),
    .sp_low_wdata(sp_low_wdata), .push_req(push_req), .push_data(push_data),
    .pop_req(pop_req), .irq_req(irq_req), .trap_req(trap_req), .call_req(call_req),
    .ret_req(ret_req), .return_from_interrupt_instruction_req(return_from_interrupt_instruction_req), .pc_in(pc_in), .x_in(x_in), .acc_in(acc_in),
    .flags_q(flags_q), .sp_q(sp_q), .branch_taken_q(branch_taken_q),
    .irq_pending_q(irq_pending_q), .irq_take_q(irq_take_q), .busy_q(busy_q),
    .pop_data_q(pop_data_q), .pop_valid_q(pop_valid_q), .pc_out_q(pc_out_q),
    .x_out_q(x_out_q), .acc_out_q(acc_out_q), .restore_done_q(restore_done_q)
  );

  // ----------------------------------------
  // clock
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // counts one-cycle pulses away from the launching edge
  always @(negedge clk) begin
    if (restore_done_q === 1'b1) done_cnt++;
    if (irq_take_q === 1'b1) take_cnt++;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask

  task automatic op(input cfsp_op_t o, input logic [7:0] r, input logic c,
                    input logic [7:0] a = 8'h00, input logic [7:0] b = 8'h00);
    flag_op = o;
    alu_result = r;
    alu_carry = c;
    alu_a = a;
    alu_b = b;
    tick();
    flag_op = CFSP_OP_NONE;
    tick();
  endtask

  task automatic wrf(input logic [7:0] v);
    flags_wdata = v;
    pulse(flags_wr);
    tick();
  endtask

  task automatic wrsp(input logic [7:0] v);
    sp_low_wdata = v;
    pulse(sp_low_wr);
    tick();
  endtask

  task automatic push(input logic [7:0] v);
    push_data = v;
    pulse(push_req);
    tick();
  endtask

  task automatic pop(output logic [7:0] v);
    pulse(pop_req);
    for (int i = 0; i < 4 && pop_valid_q !== 1'b1; i++) tick();
    `CHK("pop_valid", 1'b1, pop_valid_q)
    v = pop_data_q;
    tick();
  endtask

  // waits for a running sequence to finish
  task automatic idle();
    tick(3);
    for (int i = 0; i < 30 && busy_q !== 1'b0; i++) tick();
    `CHK("busy", 1'b0, busy_q)
    tick();
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rst, alu_a, alu_b, alu_result, alu_carry, flags_wr, flags_wdata} = '0;
    {sp_reset_instruction, sp_low_wr, sp_low_wdata, push_req, push_data, pop_req} = '0;
    {irq_req, trap_req, call_req, ret_req, return_from_interrupt_instruction_req, pc_in, x_in, acc_in} = '0;
    flag_op = CFSP_OP_NONE;
    branch_sel = CFSP_BR_HALF;
    mismatches = 0;
    cmp_count = 0;
    rst = 1'b1;
    tick(8);
    rst = 1'b0;
    `CHK("sp_reset", 16'h017F, sp_q)
    op(CFSP_OP_ADD, 8'h10, 1'b0, 8'h0F, 8'h01);
    `CHK("flags_add_h", 8'hF8, flags_q)
    op(CFSP_OP_ADC, 8'h33, 1'b0, 8'h11, 8'h22);
    `CHK("flags_adc_noh", 8'hE8, flags_q)
    op(CFSP_OP_ADD, 8'h10, 1'b1, 8'h88, 8'h88);
    `CHK("flags_add_c", 8'hF9, flags_q)
    op(CFSP_OP_LOGIC, 8'h80, 1'b0);
    `CHK("flags_logic_n", 8'hFD, flags_q)
    op(CFSP_OP_SUB, 8'h00, 1'b0);
    `CHK("flags_sub_z", 8'hFA, flags_q)
    op(CFSP_OP_SCF, 8'h00, 1'b0);
    `CHK("flags_scf", 8'hFB, flags_q)
    op(CFSP_OP_RCF, 8'h00, 1'b1);
    `CHK("flags_rcf", 8'hFA, flags_q)
    op(CFSP_OP_SHIFT, 8'h01, 1'b1);
    `CHK("flags_shift", 8'hF9, flags_q)
    op(CFSP_OP_BTJ, 8'h00, 1'b0);
    `CHK("flags_btj", 8'hF8, flags_q)
    op(CFSP_OP_RIM, 8'h00, 1'b0);
    `CHK("flags_rim", 8'hF0, flags_q)
    op(CFSP_OP_SIM, 8'h00, 1'b0);
    `CHK("flags_sim", 8'hF8, flags_q)
    for (int p = 0; p < 2; p++) begin
      wrf(p ? 8'hFF : 8'h00);
      fv = p ? 8'hFF : 8'hE0;
      `CHK("flags_load", fv, flags_q)
      for (int b = 0; b < 10; b++) begin
        branch_sel = cfsp_branch_t'(b);
        tick(2);
        `CHK("branch_taken", fv[4 - b / 2] ^ b[0], branch_taken_q)
      end
    end
    wrsp(8'h00);
    `CHK("sp_low_load", 16'h0100, sp_q)
    wrsp(8'hFF);
    `CHK("sp_fixed_bits", 16'h017F, sp_q)
    push(8'hA5);
    `CHK("sp_push", 16'h017E, sp_q)
    pop(d);
    `CHK("pop_data", 8'hA5, d)
    `CHK("sp_pop", 16'h017F, sp_q)
    wrsp(8'h00);
    push(8'h3C);
    `CHK("sp_wrap_down", 16'h017F, sp_q)
    pop(d);
    `CHK("sp_wrap_up", 16'h0100, sp_q)
    `CHK("wrap_data", 8'h3C, d)
    pulse(sp_reset_instruction);
    tick();
    `CHK("sp_rsp", 16'h017F, sp_q)
    pc_in = 16'h1234;
    pulse(call_req);
    idle();
    `CHK("sp_call", 16'h017D, sp_q)
    pc_in = 16'h0000;
    pulse(ret_req);
    idle();
    `CHK("ret_pc", 16'h1234, pc_out_q)
    `CHK("sp_ret", 16'h017F, sp_q)
    `CHK("ret_done", 1, done_cnt)
    wrf(8'hE8);
    {pc_in, x_in, acc_in} = {16'hABCD, 8'h5A, 8'hC3};
    pulse(irq_req);
    tick(3);
    `CHK("irq_latched", 1'b1, irq_pending_q)
    `CHK("sp_masked", 16'h017F, sp_q)
    op(CFSP_OP_RIM, 8'h00, 1'b0);
    idle();
    `CHK("sp_irq", 16'h017A, sp_q)
    `CHK("flags_irq", 8'hE8, flags_q)
    `CHK("irq_cleared", 1'b0, irq_pending_q)
    `CHK("irq_take", 1, take_cnt)
    {pc_in, x_in, acc_in} = '0;
    pulse(return_from_interrupt_instruction_req);
    idle();
    `CHK("return_from_interrupt_instruction_flags", 8'hE0, flags_q)
    `CHK("return_from_interrupt_instruction_pc", 16'hABCD, pc_out_q)
    `CHK("return_from_interrupt_instruction_x", 8'h5A, x_out_q)
    `CHK("return_from_interrupt_instruction_acc", 8'hC3, acc_out_q)
    `CHK("sp_return_from_interrupt_instruction", 16'h017F, sp_q)
    `CHK("return_from_interrupt_instruction_done", 2, done_cnt)
    op(CFSP_OP_SIM, 8'h00, 1'b0);
    {pc_in, x_in, acc_in} = {16'h2468, 8'h11, 8'h22};
    pulse(trap_req);
    idle();
    `CHK("sp_trap", 16'h017A, sp_q)
    for (int i = 0; i < 5; i++) begin
      pop(d);
      `CHK("ctx_order", ctx[i], d)
    end
    `CHK("sp_ctx", 16'h017F, sp_q)
    end_sim();
  end
endmodule
